// File: design/sdio_core.sv
/*
  Data I/O path of a synchronous flow-through burst SRAM: access decode,
  burst sequencing, data and parity lane capture and drive, output
  enable masking, burst order strap and serial scan output timing.
  Assumes the host drives address and control synchronous to i_sys_clk;
  output enable, strap and the test pins are asynchronous to it.
*/
`timescale 1ns/10ps
module sdio_core
  import sdio_pkg::*;
#(
  parameter int ADDR_W = SDIO_ADDR_W,
  parameter int NB = SDIO_BYTES
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clock_qualifier_n,
  input wire logic i_chip_select_1_n,
  input wire logic i_chip_select_2,
  input wire logic i_chip_select_3_n,
  input wire logic i_advance_load,
  input wire logic i_write_enable_n,
  input wire logic [NB-1:0] i_byte_write_select_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_output_enable_n,
  input wire logic [NB*SDIO_BYTE_W-1:0] i_data_lanes,
  output logic [NB*SDIO_BYTE_W-1:0] o_data_lanes,
  output logic o_data_lanes_oe,
  input wire logic [NB-1:0] i_parity_io_lanes,
  output logic [NB-1:0] o_parity_io_lanes,
  output logic o_parity_io_lanes_oe,
  input wire logic i_burst_mode,
  input wire logic i_test_clk,
  input wire logic i_test_data_in,
  output logic o_test_data_out
);

  localparam int DW = NB * SDIO_LANE_W;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic oe_n_s1_q, oe_n_s2_q;
  logic mode_s1_q, mode_s2_q, mode_q, mode_d, mode_ok_q, mode_ok_d, mode_v1_q, mode_v2_q;
  logic tck_s1_q, tck_s2_q, tck_s3_q, tdi_s1_q, tdi_s2_q;
  logic scan_bit_q, scan_bit_d, tdo_q, tdo_d;
  logic taken, sel_all, start, advance, mem_rd_en, mem_wr_en;
  sdio_op_e op_q, op_d;
  logic [ADDR_W-1:0] base_q, base_d, cur_addr;
  logic [SDIO_BURST_W-1:0] cnt_q, cnt_d;
  logic wr_pend_q, wr_pend_d, oe_q, oe_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [DW-1:0] mem_rd_data, mem_wr_data;
  logic [NB-1:0] mem_lane_en;

  // burst address low bits for either order
  function automatic logic [SDIO_BURST_W-1:0] burst_low(
    input logic mode,
    input logic [SDIO_BURST_W-1:0] start_lo,
    input logic [SDIO_BURST_W-1:0] count
  );
    burst_low = (mode == SDIO_MODE_LINEAR) ? start_lo + count : start_lo ^ count;
  endfunction : burst_low

  // ****************************************************************
  // synchronisers for asynchronous pins
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      oe_n_s1_q <= SDIO_OE_N_RESET;
      oe_n_s2_q <= SDIO_OE_N_RESET;
      mode_s1_q <= SDIO_MODE_INTERLEAVE;
      mode_s2_q <= SDIO_MODE_INTERLEAVE;
      tck_s1_q <= 1'h0;
      tck_s2_q <= 1'h0;
      tck_s3_q <= 1'h0;
      tdi_s1_q <= 1'h0;
      tdi_s2_q <= 1'h0;
      mode_v1_q <= 1'h0;
      mode_v2_q <= 1'h0;
    end
    else
    begin
      oe_n_s1_q <= i_output_enable_n;
      oe_n_s2_q <= oe_n_s1_q;
      mode_s1_q <= i_burst_mode;
      mode_s2_q <= mode_s1_q;
      tck_s1_q <= i_test_clk;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tdi_s1_q <= i_test_data_in;
      tdi_s2_q <= tdi_s1_q;
      mode_v1_q <= 1'h1;  // age chain, strap sync valid when it reaches v2
      mode_v2_q <= mode_v1_q;
    end
  end

  // ****************************************************************
  // burst order strap, caught once after reset release
  // ****************************************************************
  always_comb
  begin
    mode_d = mode_q;
    mode_ok_d = mode_ok_q || mode_v2_q;
    if (!mode_ok_q && mode_v2_q)
    begin
      mode_d = mode_s2_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode_q <= SDIO_MODE_INTERLEAVE;
      mode_ok_q <= 1'h0;
    end
    else
    begin
      mode_q <= mode_d;
      mode_ok_q <= mode_ok_d;
    end
  end

  // ****************************************************************
  // access decode and burst sequencing
  // ****************************************************************
  assign taken = !i_clock_qualifier_n;
  assign sel_all = !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n;
  assign start = taken && sel_all && !i_advance_load;
  assign advance = taken && i_advance_load;
  assign cur_addr = start ? i_addr
    : {base_q[ADDR_W-1:SDIO_BURST_W],
       burst_low(mode_q, base_q[SDIO_BURST_W-1:0], cnt_q + SDIO_BURST_STEP)};

  always_comb
  begin
    op_d = op_q;
    base_d = base_q;
    cnt_d = cnt_q;
    wr_pend_d = wr_pend_q;
    wr_addr_d = wr_addr_q;
    if (taken)
    begin
      wr_pend_d = 1'h0;
      if (start)
      begin
        op_d = i_write_enable_n ? SDIO_READ : SDIO_WRITE;
        base_d = i_addr;
        cnt_d = SDIO_BURST_ZERO;
      end
      else if (advance)
      begin
        cnt_d = cnt_q + SDIO_BURST_STEP;
      end
      else
      begin
        op_d = SDIO_IDLE;
      end
      if ((start || advance) && op_d == SDIO_WRITE)
      begin
        wr_pend_d = 1'h1;
        wr_addr_d = cur_addr;
      end
    end
    oe_d = (op_d == SDIO_READ) && !oe_n_s2_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      op_q <= SDIO_IDLE;
      base_q <= '0;
      cnt_q <= SDIO_BURST_ZERO;
      wr_pend_q <= 1'h0;
      wr_addr_q <= '0;
      oe_q <= 1'h0;
    end
    else
    begin
      op_q <= op_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      oe_q <= oe_d;
    end
  end

  // ****************************************************************
  // array access: read now, write data one edge later
  // ****************************************************************
  assign mem_rd_en = (start || advance) && op_d == SDIO_READ;
  assign mem_wr_en = taken && wr_pend_q;

  always_comb
  begin
    for (int b = 0; b < NB; b++)
    begin
      mem_wr_data[b*SDIO_LANE_W +: SDIO_LANE_W] =
        {i_parity_io_lanes[b], i_data_lanes[b*SDIO_BYTE_W +: SDIO_BYTE_W]};
      mem_lane_en[b] = !i_byte_write_select_n[b];
    end
  end

  sdio_array #(
    .ADDR_W(ADDR_W),
    .LANES(NB),
    .LANE_W(SDIO_LANE_W)
  ) u_array (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_rd_en(mem_rd_en),
    .i_rd_addr(cur_addr),
    .o_rd_data(mem_rd_data),
    .i_wr_en(mem_wr_en),
    .i_wr_addr(wr_addr_q),
    .i_wr_data(mem_wr_data),
    .i_wr_lane_en(mem_lane_en)
  );

  // split array word back into data and parity lanes
  always_comb
  begin
    for (int b = 0; b < NB; b++)
    begin
      o_data_lanes[b*SDIO_BYTE_W +: SDIO_BYTE_W] =
        mem_rd_data[b*SDIO_LANE_W +: SDIO_BYTE_W];
      o_parity_io_lanes[b] = mem_rd_data[b*SDIO_LANE_W + SDIO_BYTE_W];
    end
  end

  // ****************************************************************
  // lane drive: read phase and output enable low only
  // ****************************************************************
  assign o_data_lanes_oe = oe_q;
  assign o_parity_io_lanes_oe = oe_q;

  // ****************************************************************
  // scan output: sample on test clock rise, drive on fall
  // ****************************************************************
  always_comb
  begin
    scan_bit_d = scan_bit_q;
    tdo_d = tdo_q;
    if (tck_s2_q && !tck_s3_q)
    begin
      scan_bit_d = tdi_s2_q;
    end
    if (!tck_s2_q && tck_s3_q)
    begin
      tdo_d = scan_bit_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      scan_bit_q <= 1'h0;
      tdo_q <= 1'h0;
    end
    else
    begin
      scan_bit_q <= scan_bit_d;
      tdo_q <= tdo_d;
    end
  end

  assign o_test_data_out = tdo_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_load;
    !i_clock_qualifier_n && sel_all && !i_advance_load;
  endsequence
  sequence s_write_load;
    s_load ##0 !i_write_enable_n;
  endsequence

  chk_oe_high_released: assert property (
    oe_n_s2_q |=> !o_data_lanes_oe && !o_parity_io_lanes_oe)
    else $error("lanes driven while output enable high");
  chk_read_drives: assert property (
    s_load ##0 i_write_enable_n ##0 !oe_n_s2_q |=> o_data_lanes_oe)
    else $error("read phase not driven with enable low");
  chk_write_released: assert property (s_write_load |=> !o_data_lanes_oe && wr_pend_q)
    else $error("lanes driven in write data phase");
  chk_deselect_released: assert property (
    !i_clock_qualifier_n && !sel_all && !i_advance_load |=> !o_data_lanes_oe)
    else $error("lanes driven while deselected");
  chk_write_captures: assert property (
    s_write_load ##1 !i_clock_qualifier_n |-> mem_wr_en)
    else $error("write data not captured");
  chk_hold_stall: assert property (
    i_clock_qualifier_n |=> $stable(cnt_q) && $stable(op_q) && $stable(o_data_lanes))
    else $error("state changed on ignored edge");
  chk_burst_wraps: assert property (
    !i_clock_qualifier_n && i_advance_load |=> cnt_q == $past(cnt_q) + SDIO_BURST_STEP)
    else $error("burst counter did not advance");
  chk_linear_order: assert property (mode_ok_q && !start
    && mode_q == SDIO_MODE_LINEAR |-> cur_addr[1:0] == base_q[1:0] + cnt_q + 2'h1)
    else $error("linear burst order wrong");
  chk_interleave_order: assert property (mode_ok_q && !start
    && mode_q == SDIO_MODE_INTERLEAVE |-> cur_addr[1:0] == (base_q[1:0] ^ (cnt_q + 2'h1)))
    else $error("interleaved burst order wrong");
  chk_parity_masked: assert property (mem_wr_en |->
    mem_lane_en == ~i_byte_write_select_n && mem_wr_data[SDIO_BYTE_W] == i_parity_io_lanes[0])
    else $error("parity lane not paired with its byte");
  chk_scan_falling: assert property (
    $changed(o_test_data_out) |-> $past(!tck_s2_q && tck_s3_q))
    else $error("scan output changed off falling edge");

endmodule : sdio_core

// File: design/sdio_pkg.sv
/*
  Shared constants for the burst SRAM data I/O path: geometry defaults,
  burst counter width, lane layout and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sdio_pkg;

  // ****************************************************************
  // geometry defaults
  // ****************************************************************
  localparam int SDIO_ADDR_W = 19;   // word address width
  localparam int SDIO_BYTES = 4;     // byte lanes per word
  localparam int SDIO_BYTE_W = 8;    // data bits per byte lane
  localparam int SDIO_LANE_W = 9;    // byte plus its parity bit in storage

  // ****************************************************************
  // burst counter
  // ****************************************************************
  localparam int SDIO_BURST_W = 2;   // counter covers the two lowest address bits
  localparam logic [SDIO_BURST_W-1:0] SDIO_BURST_ZERO = 2'h0;
  localparam logic [SDIO_BURST_W-1:0] SDIO_BURST_STEP = 2'h1;

  // ****************************************************************
  // strap encoding and reset values
  // ****************************************************************
  localparam logic SDIO_MODE_LINEAR = 1'h0;       // strap tied low
  localparam logic SDIO_MODE_INTERLEAVE = 1'h1;   // strap high or floating
  localparam logic SDIO_OE_N_RESET = 1'h1;        // output enable released

  // access state of the data phase that follows a taken edge
  typedef enum logic [1:0] {SDIO_IDLE, SDIO_READ, SDIO_WRITE} sdio_op_e;

endpackage : sdio_pkg

// File: design/sdio_array.sv
/*
  Storage array of the SRAM: one write port with per-lane enables and one
  read port whose data come out of a register.
  Assumes write and read addresses are stable at the rising clock edge.
*/
`timescale 1ns/10ps
module sdio_array
  import sdio_pkg::*;
#(
  parameter int ADDR_W = SDIO_ADDR_W,
  parameter int LANES = SDIO_BYTES,
  parameter int LANE_W = SDIO_LANE_W
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [LANES*LANE_W-1:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [LANES*LANE_W-1:0] i_wr_data,
  input wire logic [LANES-1:0] i_wr_lane_en
);

  logic [LANES*LANE_W-1:0] mem [0:(2**ADDR_W)-1];
  logic [LANES*LANE_W-1:0] rd_data_d;
  logic [LANES*LANE_W-1:0] rd_data_q;

  // ****************************************************************
  // write port, one enable per lane
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (i_wr_en && i_wr_lane_en[l])
      begin
        mem[i_wr_addr][l*LANE_W +: LANE_W] <= i_wr_data[l*LANE_W +: LANE_W];
      end
    end
  end

  // ****************************************************************
  // registered read port, holds when not enabled
  // ****************************************************************
  always_comb
  begin
    rd_data_d = rd_data_q;
    if (i_rd_en)
    begin
      rd_data_d = mem[i_rd_addr];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  assign o_rd_data = rd_data_q;

endmodule : sdio_array

// File: verification/sdio_host_model.sv
/*
  Host controller model for the burst SRAM data path: drives the bus one
  beat per clock and resolves the shared data and parity wires.
  Assumes one bench process calls beat, once per clock.
*/
`timescale 1ns/10ps
module sdio_host_model
  import sdio_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic i_sys_clk,
  input wire logic [31:0] i_dev_data,
  input wire logic [3:0] i_dev_parity,
  input wire logic i_dev_oe,
  output logic o_clock_qualifier_n,
  output logic o_chip_select_1_n,
  output logic o_chip_select_2,
  output logic o_chip_select_3_n,
  output logic o_advance_load,
  output logic o_write_enable_n,
  output logic [3:0] o_byte_write_select_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [31:0] o_data_wire,
  output logic [3:0] o_parity_wire
);
  logic [35:0] drv_v = 36'h0;
  logic [35:0] pend_v = 36'h0;
  logic [3:0] pend_bw = 4'hF;
  logic wr_op = 1'b0;

  // ****************************************************************
  // wire resolution and beat driver
  // ****************************************************************
  // device wins when it drives, else host value or toggling junk
  assign o_data_wire = i_dev_oe ? i_dev_data : drv_v[35:4];
  assign o_parity_wire = i_dev_oe ? i_dev_parity : drv_v[3:0];

  // idle bus at time zero: deselected, qualifier low
  initial
  begin
    o_clock_qualifier_n = 1'b0;
    o_chip_select_1_n = 1'b1;
    o_chip_select_2 = 1'b0;
    o_chip_select_3_n = 1'b1;
    o_advance_load = 1'b0;
    o_write_enable_n = 1'b1;
    o_byte_write_select_n = 4'hF;
    o_addr = '0;
  end

  // one beat: controls now, write data of the previous beat with them
  task automatic beat(input logic sel, input logic adv, input logic we_n,
    input logic [ADDR_W-1:0] a, input logic [3:0] bw_n, input logic [35:0] v,
    input logic hold);
    @(negedge i_sys_clk);
    o_clock_qualifier_n = hold;
    if (!hold)
    begin
      o_chip_select_1_n = !sel;
      o_chip_select_2 = sel;
      o_chip_select_3_n = !sel;
      o_advance_load = adv;
      o_write_enable_n = we_n;
      o_addr = a;
      o_byte_write_select_n = wr_op ? pend_bw : 4'hF;
      drv_v = wr_op ? pend_v : ~drv_v;
      if (!adv)
        wr_op = sel & !we_n;
      pend_v = v;
      pend_bw = bw_n;
    end
    @(posedge i_sys_clk);
  endtask : beat

endmodule : sdio_host_model

// File: verification/sdio_core_tb_top.sv
/*
  Self-checking bench of the SRAM data path: host model drives the bus,
  a monitor matches every driven read against a queue of expected words.
  Assumes the core with an 8-bit address and four byte lanes.
*/
`timescale 1ns/10ps
`define SDIO_CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      num_errors++; \
      $display("FAIL %s expected %h seen %h", nm, ex, got); \
    end \
  end
module sdio_core_tb_top
  import sdio_pkg::*;
();
  localparam int AW = 8;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic oe_n = 1'b1;
  logic mode = 1'b0;
  logic tck = 1'b0;
  logic tdi = 1'b0;
  logic qn, cs1n, cs2, cs3n, adv, wen, lanes_oe, par_oe, tdo;
  logic [3:0] bwn, par_w, par_o;
  logic [AW-1:0] addr;
  logic [31:0] data_w, data_o;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 41;
  logic [35:0] mem [0:255];
  logic [35:0] exp_q [$];

  sdio_core #(.ADDR_W(AW)) sdio_core_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clock_qualifier_n(qn),
    .i_chip_select_1_n(cs1n), .i_chip_select_2(cs2), .i_chip_select_3_n(cs3n),
    .i_advance_load(adv), .i_write_enable_n(wen), .i_byte_write_select_n(bwn),
    .i_addr(addr), .i_output_enable_n(oe_n), .i_data_lanes(data_w),
    .o_data_lanes(data_o), .o_data_lanes_oe(lanes_oe), .i_parity_io_lanes(par_w),
    .o_parity_io_lanes(par_o), .o_parity_io_lanes_oe(par_oe), .i_burst_mode(mode),
    .i_test_clk(tck), .i_test_data_in(tdi), .o_test_data_out(tdo));

  sdio_host_model #(.ADDR_W(AW)) sdio_host_model_inst (
    .i_sys_clk(i_sys_clk), .i_dev_data(data_o), .i_dev_parity(par_o),
    .i_dev_oe(lanes_oe), .o_clock_qualifier_n(qn), .o_chip_select_1_n(cs1n),
    .o_chip_select_2(cs2), .o_chip_select_3_n(cs3n), .o_advance_load(adv),
    .o_write_enable_n(wen), .o_byte_write_select_n(bwn), .o_addr(addr),
    .o_data_wire(data_w), .o_parity_wire(par_w));

  // ****************************************************************
  // clock, watchdog and result monitor
  // ****************************************************************
  // 200 MHz main clock
  initial
  begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // watchdog on total run length
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // every driven cycle must match the oldest expected word
  always @(negedge i_sys_clk)
  begin
    if (lanes_oe === 1'b1 && exp_q.size() == 0)
      `SDIO_CHK("lanes_oe", 1'b0, lanes_oe)
    else if (lanes_oe === 1'b1)
    begin
      `SDIO_CHK("lanes", exp_q[0], {data_o, par_o})
      `SDIO_CHK("parity_oe", 1'b1, par_oe)
      void'(exp_q.pop_front());
    end
  end

  // burst address of beat k, linear or interleaved
  function automatic logic [AW-1:0] seq_addr(input logic [AW-1:0] b, input int k);
    logic [1:0] lo;
    lo = mode ? (b[1:0] ^ k[1:0]) : (b[1:0] + k[1:0]);
    return {b[AW-1:2], lo};
  endfunction : seq_addr

  // four-beat burst then deselect; reads stall once on beat 1
  task automatic burst(input logic we_n, input logic [AW-1:0] b, input logic part);
    logic [35:0] v;
    logic [3:0] bw;
    logic [AW-1:0] a;
    for (int k = 0; k < 4; k++)
    begin
      a = seq_addr(b, k);
      v = 36'({$random(seed), $random(seed)});
      bw = part ? 4'($random(seed)) : 4'h0;
      sdio_host_model_inst.beat(1'b1, k != 0, we_n, b, bw, v, 1'b0);
      for (int i = 0; i < 4; i++)
        if (!we_n && !bw[i])
        begin
          mem[a][4+8*i +: 8] = v[4+8*i +: 8];
          mem[a][i] = v[i];
        end
      if (we_n && !oe_n)
        exp_q.push_back(mem[a]);
      if (we_n && k == 1)
      begin
        sdio_host_model_inst.beat(1'b1, 1'b1, 1'b1, b, 4'hF, 36'h0, 1'b1);
        if (!oe_n)
          exp_q.push_back(mem[a]);
      end
    end
    sdio_host_model_inst.beat(1'b0, 1'b0, 1'b1, b, 4'hF, 36'h0, 1'b0);
  endtask : burst

  // change output enable off the edge and let it settle
  task automatic set_oe(input logic v);
    @(negedge i_sys_clk);
    oe_n = v;
    repeat (4) @(negedge i_sys_clk);
  endtask : set_oe

  // reset with a strap value, then writes, reads and enable masking
  task automatic run(input logic m);
    logic [AW-1:0] b;
    logic [35:0] v;
    b = AW'($random(seed));
    v = 36'({$random(seed), $random(seed)});
    @(negedge i_sys_clk);
    i_rst_b = 1'b0;
    mode = m;
    oe_n = 1'b0;
    repeat (5) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    burst(1'b0, b, 1'b0);
    burst(1'b0, b, 1'b1);
    burst(1'b1, b, 1'b0);
    sdio_host_model_inst.beat(1'b0, 1'b1, 1'b1, b, 4'hF, 36'h0, 1'b0);
    set_oe(1'b1);
    burst(1'b1, b, 1'b0);
    set_oe(1'b0);
    sdio_host_model_inst.beat(1'b1, 1'b0, 1'b0, b ^ AW'(4), 4'h0, v, 1'b0);
    mem[b ^ AW'(4)] = v;
    sdio_host_model_inst.beat(1'b1, 1'b0, 1'b1, b, 4'hF, 36'h0, 1'b0);
    exp_q.push_back(mem[b]);
    sdio_host_model_inst.beat(1'b1, 1'b0, 1'b1, b ^ AW'(4), 4'hF, 36'h0, 1'b0);
    exp_q.push_back(mem[b ^ AW'(4)]);
    sdio_host_model_inst.beat(1'b0, 1'b0, 1'b1, b, 4'hF, 36'h0, 1'b0);
    $display("test burst mode %0d done", m);
  endtask : run

  // serial output must hold through the rise and change after the fall
  task automatic scan_test();
    logic prev;
    prev = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      @(negedge i_sys_clk);
      tdi = ~prev;
      @(negedge i_sys_clk);
      tck = 1'b1;
      repeat (8) @(negedge i_sys_clk);
      `SDIO_CHK("scan_hold", prev, tdo)
      tck = 1'b0;
      repeat (8) @(negedge i_sys_clk);
      `SDIO_CHK("scan_out", ~prev, tdo)
      prev = ~prev;
    end
    $display("test scan done");
  endtask : scan_test

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // main sequence: both strap settings, second reset mid-run
  initial
  begin
    run(SDIO_MODE_LINEAR);
    run(SDIO_MODE_INTERLEAVE);
    scan_test();
    repeat (4) @(negedge i_sys_clk);
    `SDIO_CHK("pending_reads", 0, exp_q.size())
    complete_run();
  end

endmodule : sdio_core_tb_top
